// [rtl/rta_alarm_bank.sv]
// alarm-compare register set with paired index/data host ports
//
// Contract
// - top bits 11 make a field always match
// - first month alarm, read/write, resets C0h
// - first month alarm index set by input
// - second seconds alarm at index 00h, reset 00h
// - second minutes alarm at index 01h, reset 00h
// - second hours alarm at index 02h, reset 00h
// - 12-hour alarm hours, bit 7 marks PM
// - 24-hour alarm hours 00-23 BCD, 00-17 binary
// - second date alarm at index 03h, reset C0h
// - second month alarm at index 04h, reset C0h
// - port 70h selects bank-0 register
// - port 71h reaches selected bank-0 register
// - port 72h selects bank-1 register
// - port 73h reaches selected bank-1 register
// - second alarm match sets flag, enable gates interrupt
// - number format bit: 0 BCD, 1 binary
// - hour format bit: 0 12-hour, 1 24-hour
// - flags clear on invalid contents or read
`timescale 1ns/10ps
module rta_alarm_bank (
  input  wire logic               clk,
  input  wire logic               reset,
  input  wire rta_pkg::rta_bus_t  host,
  output logic [7:0]              host_rdata,
  input  wire logic [7:0]         first_alarm_month_index,
  input  wire rta_pkg::rta_time_t cur_time,
  input  wire logic               first_alarm_rest_match,
  input  wire logic               contents_valid_status,
  output logic                    irq,
  output logic                    number_format_select,
  output logic                    hour_format_select,
  output logic                    first_alarm_flag,
  output logic                    second_alarm_flag
);
  import rta_pkg::*;

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  logic [7:0] idx0_r;
  logic [7:0] idx1_r;
  logic [7:0] first_alarm_month_r;
  rta_time_t  alarm2_r;
  logic       first_alarm_irq_enable_r;
  logic       second_alarm_irq_enable_r;
  logic [7:0] host_rdata_nxt;
  logic       wr0;
  logic       wr1;
  logic       rd_flags;
  logic [NFIELDS-1:0] hit2;
  logic       hit1;
  logic       match2;
  logic       match1;
  logic       match2_prev_r;
  logic       match1_prev_r;
  logic       event2;
  logic       event1;

  assign wr0      = host.wr && (host.addr == OFS_DAT0);
  assign wr1      = host.wr && (host.addr == OFS_DAT1);
  assign rd_flags = host.rd && (host.addr == OFS_DAT0) && (idx0_r == IDX_FLAGS);

  // ----------------------------------------------------------------
  // index ports
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (reset) begin
      idx0_r <= RST_IDX;
    end else if (host.wr && host.addr == OFS_IDX0) begin
      idx0_r <= host.wdata;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      idx1_r <= RST_IDX;
    end else if (host.wr && host.addr == OFS_IDX1) begin
      idx1_r <= host.wdata;
    end
  end

  // ----------------------------------------------------------------
  // bank 0: first month alarm and control
  // ----------------------------------------------------------------
  // the month alarm index wins over a control index if software aliases them
  always_ff @(posedge clk) begin
    if (reset) begin
      first_alarm_month_r <= RST_MON;
    end else if (wr0 && idx0_r == first_alarm_month_index) begin
      first_alarm_month_r <= host.wdata;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      first_alarm_irq_enable_r  <= 1'b0;
      second_alarm_irq_enable_r <= 1'b0;
      number_format_select      <= 1'b0;
      hour_format_select        <= 1'b0;
    end else begin
      if (wr0 && idx0_r == IDX_CTL_B && idx0_r != first_alarm_month_index) begin
        first_alarm_irq_enable_r  <= host.wdata[BIT_A1IE];
        second_alarm_irq_enable_r <= host.wdata[BIT_SECOND_ALARM_IRQ_ENABLE];
        number_format_select      <= host.wdata[BIT_NFMT];
        hour_format_select        <= host.wdata[BIT_HFMT];
      end
      // enables drop while the backed-up contents are not trustworthy
      if (!contents_valid_status) begin
        first_alarm_irq_enable_r  <= 1'b0;
        second_alarm_irq_enable_r <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // bank 1: second alarm
  // ----------------------------------------------------------------
  // hour bytes are stored raw; the time counters use the same encoding
  // for the selected hour and number format, so equality covers AM/PM
  always_ff @(posedge clk) begin
    if (reset) begin
      alarm2_r.sec   <= RST_TIME;
      alarm2_r.min   <= RST_TIME;
      alarm2_r.hour  <= RST_TIME;
      alarm2_r.day   <= RST_DAY;
      alarm2_r.month <= RST_MON;
    end else if (wr1) begin
      case (idx1_r)
        IDX_SEC2:  alarm2_r.sec   <= host.wdata;
        IDX_MIN2:  alarm2_r.min   <= host.wdata;
        IDX_HOUR2: alarm2_r.hour  <= host.wdata;
        IDX_DAY2:  alarm2_r.day   <= host.wdata;
        IDX_MON2:  alarm2_r.month <= host.wdata;
        default:   alarm2_r       <= alarm2_r;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // read path
  // ----------------------------------------------------------------
  function automatic logic [7:0] bank1_read(input rta_time_t a, input logic [7:0] idx);
    case (idx)
      IDX_SEC2:  bank1_read = a.sec;
      IDX_MIN2:  bank1_read = a.min;
      IDX_HOUR2: bank1_read = a.hour;
      IDX_DAY2:  bank1_read = a.day;
      IDX_MON2:  bank1_read = a.month;
      default:   bank1_read = 8'h00;
    endcase
  endfunction : bank1_read

  always_comb begin
    host_rdata_nxt = 8'h00;
    case (host.addr)
      OFS_IDX0: host_rdata_nxt = idx0_r;
      OFS_IDX1: host_rdata_nxt = idx1_r;
      OFS_DAT1: host_rdata_nxt = bank1_read(alarm2_r, idx1_r);
      OFS_DAT0: begin
        if (idx0_r == first_alarm_month_index) begin
          host_rdata_nxt = first_alarm_month_r;
        end else if (idx0_r == IDX_CTL_B) begin
          host_rdata_nxt[BIT_A1IE] = first_alarm_irq_enable_r;
          host_rdata_nxt[BIT_SECOND_ALARM_IRQ_ENABLE] = second_alarm_irq_enable_r;
          host_rdata_nxt[BIT_NFMT] = number_format_select;
          host_rdata_nxt[BIT_HFMT] = hour_format_select;
        end else if (idx0_r == IDX_FLAGS) begin
          host_rdata_nxt[BIT_FIRST_ALARM_FLAG] = first_alarm_flag;
          host_rdata_nxt[BIT_SECOND_ALARM_FLAG] = second_alarm_flag;
        end else if (idx0_r == IDX_VALID) begin
          host_rdata_nxt[BIT_VAL] = contents_valid_status;
        end
      end
      default: host_rdata_nxt = 8'h00;
    endcase
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      host_rdata <= 8'h00;
    end else if (host.rd) begin
      host_rdata <= host_rdata_nxt;
    end
  end

  // ----------------------------------------------------------------
  // match and flags
  // ----------------------------------------------------------------
  rta_field_match u_sec (.clk(clk), .reset(reset), .alarm(alarm2_r.sec),
                         .current(cur_time.sec), .hit_r(hit2[0]));
  rta_field_match u_min (.clk(clk), .reset(reset), .alarm(alarm2_r.min),
                         .current(cur_time.min), .hit_r(hit2[1]));
  rta_field_match u_hour (.clk(clk), .reset(reset), .alarm(alarm2_r.hour),
                          .current(cur_time.hour), .hit_r(hit2[2]));
  rta_field_match u_day (.clk(clk), .reset(reset), .alarm(alarm2_r.day),
                         .current(cur_time.day), .hit_r(hit2[3]));
  rta_field_match u_mon (.clk(clk), .reset(reset), .alarm(alarm2_r.month),
                         .current(cur_time.month), .hit_r(hit2[4]));
  rta_field_match u_mon1 (.clk(clk), .reset(reset), .alarm(first_alarm_month_r),
                          .current(cur_time.month), .hit_r(hit1));

  assign match2 = &hit2;
  assign match1 = hit1 && first_alarm_rest_match;

  // a held match raises the flag once, so a read can clear it for good
  always_ff @(posedge clk) begin
    if (reset) begin
      match2_prev_r <= 1'b0;
      match1_prev_r <= 1'b0;
    end else begin
      match2_prev_r <= match2;
      match1_prev_r <= match1;
    end
  end

  assign event2 = match2 && !match2_prev_r && contents_valid_status;
  assign event1 = match1 && !match1_prev_r && contents_valid_status;

  rta_sticky_flag u_flag2 (.clk(clk), .reset(reset), .set(event2),
                           .clr(rd_flags || !contents_valid_status), .q_r(second_alarm_flag));
  rta_sticky_flag u_flag1 (.clk(clk), .reset(reset), .set(event1),
                           .clr(rd_flags || !contents_valid_status), .q_r(first_alarm_flag));

  always_ff @(posedge clk) begin
    if (reset) begin
      irq <= 1'b0;
    end else begin
      irq <= (second_alarm_flag && second_alarm_irq_enable_r)
          || (first_alarm_flag && first_alarm_irq_enable_r);
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking

  sequence s_wr_ctl;
    wr0 && idx0_r == IDX_CTL_B && idx0_r != first_alarm_month_index;
  endsequence

  sequence s_match_rise;
    match2 && !match2_prev_r && contents_valid_status;
  endsequence

  a_month1_reset: assert property (reset |=> first_alarm_month_r == RST_MON)
    else $error("first month alarm reset value wrong");

  a_month1_index: assert property (disable iff (reset)
    (wr0 && idx0_r == first_alarm_month_index) |=> first_alarm_month_r == $past(host.wdata))
    else $error("first month alarm not written at programmed index");

  a_bank1_reset: assert property (reset |=> alarm2_r.sec == RST_TIME
    && alarm2_r.min == RST_TIME && alarm2_r.hour == RST_TIME
    && alarm2_r.day == RST_DAY && alarm2_r.month == RST_MON)
    else $error("second alarm reset values wrong");

  a_sec2_write: assert property (disable iff (reset)
    (wr1 && idx1_r == IDX_SEC2) |=> alarm2_r.sec == $past(host.wdata))
    else $error("seconds alarm write misrouted");

  a_mon2_write: assert property (disable iff (reset)
    (wr1 && idx1_r == IDX_MON2) |=> alarm2_r.month == $past(host.wdata))
    else $error("month alarm write misrouted");

  a_idx0_write: assert property (disable iff (reset)
    (host.wr && host.addr == OFS_IDX0) |=> idx0_r == $past(host.wdata))
    else $error("bank 0 index not taken");

  a_idx1_read: assert property (disable iff (reset)
    (host.rd && host.addr == OFS_IDX1) |=> host_rdata == $past(idx1_r))
    else $error("bank 1 index readback wrong");

  a_format_bits: assert property (disable iff (reset) s_wr_ctl |=>
    number_format_select == $past(host.wdata[BIT_NFMT])
    && hour_format_select == $past(host.wdata[BIT_HFMT]))
    else $error("format bits not written");

  a_alarm2_flag: assert property (disable iff (reset)
    s_match_rise |=> second_alarm_flag ##1 (irq == second_alarm_irq_enable_r || first_alarm_flag))
    else $error("second alarm flag or interrupt missing");

  a_invalid_clear: assert property (disable iff (reset)
    !contents_valid_status |=> !second_alarm_flag && !second_alarm_irq_enable_r)
    else $error("flag survived invalid contents");

  a_read_clear: assert property (disable iff (reset)
    (rd_flags && !event2) |=> !second_alarm_flag)
    else $error("flag not cleared by read");

  a_match_all: assert property (disable iff (reset)
    $rose(second_alarm_flag) |-> $past(match2) && $past(contents_valid_status))
    else $error("flag set without full match");

  a_min2_write: assert property (disable iff (reset)
    (wr1 && idx1_r == IDX_MIN2) |=> alarm2_r.min == $past(host.wdata))
    else $error("minutes alarm write misrouted");

  a_hour2_write: assert property (disable iff (reset)
    (wr1 && idx1_r == IDX_HOUR2) |=> alarm2_r.hour == $past(host.wdata))
    else $error("hours alarm write misrouted");

  a_day2_write: assert property (disable iff (reset)
    (wr1 && idx1_r == IDX_DAY2) |=> alarm2_r.day == $past(host.wdata))
    else $error("date alarm write misrouted");

  a_idx1_write: assert property (disable iff (reset)
    (host.wr && host.addr == OFS_IDX1) |=> idx1_r == $past(host.wdata))
    else $error("bank 1 index not taken");

  a_idx0_read: assert property (disable iff (reset)
    (host.rd && host.addr == OFS_IDX0) |=> host_rdata == $past(idx0_r))
    else $error("bank 0 index readback wrong");

  a_month1_read: assert property (disable iff (reset)
    (host.rd && host.addr == OFS_DAT0 && idx0_r == first_alarm_month_index)
    |=> host_rdata == $past(first_alarm_month_r))
    else $error("first month alarm readback wrong");

  a_hour2_read: assert property (disable iff (reset)
    (host.rd && host.addr == OFS_DAT1 && idx1_r == IDX_HOUR2) |=> host_rdata == $past(alarm2_r.hour))
    else $error("hours alarm readback wrong");

  a_rdata_hold: assert property (disable iff (reset)
    !host.rd |=> $stable(host_rdata))
    else $error("read data changed without a read");

  a_enable_write: assert property (disable iff (reset) s_wr_ctl ##0 contents_valid_status |=>
    second_alarm_irq_enable_r == $past(host.wdata[BIT_SECOND_ALARM_IRQ_ENABLE])
    && first_alarm_irq_enable_r == $past(host.wdata[BIT_A1IE]))
    else $error("interrupt enables not written");

  a_alarm1_irq: assert property (disable iff (reset)
    (first_alarm_flag && first_alarm_irq_enable_r) |=> irq)
    else $error("first alarm interrupt missing");

  a_idle_no_irq: assert property (disable iff (reset)
    (!first_alarm_flag && !second_alarm_flag) |=> !irq)
    else $error("interrupt without a flag");

  a_invalid_first: assert property (disable iff (reset)
    !contents_valid_status |=> !first_alarm_flag && !first_alarm_irq_enable_r)
    else $error("first flag survived invalid contents");
endmodule : rta_alarm_bank

// [rtl/rta_field_match.sv]
// one alarm field compared against the current time field
`timescale 1ns/10ps
module rta_field_match (
  input  wire logic       clk,
  input  wire logic       reset,
  input  wire logic [7:0] alarm,
  input  wire logic [7:0] current,
  output logic            hit_r
);
  import rta_pkg::*;

  always_ff @(posedge clk) begin
    if (reset) begin
      hit_r <= 1'b0;
    end else begin
      hit_r <= (alarm[7:6] == DONT_CARE) || (alarm == current);
    end
  end

  a_dont_care_hit: assert property (@(posedge clk) disable iff (reset)
    (alarm[7:6] == DONT_CARE) |=> hit_r)
    else $error("don't-care field did not match");

  a_field_miss: assert property (@(posedge clk) disable iff (reset)
    (alarm[7:6] != DONT_CARE && alarm != current) |=> !hit_r)
    else $error("differing field matched");
endmodule : rta_field_match

// [rtl/rta_pkg.sv]
// package: offsets, indexes, reset values and carriers of the alarm bank
package rta_pkg;
  // host port offsets
  localparam logic [7:0] OFS_IDX0 = 8'h70;
  localparam logic [7:0] OFS_DAT0 = 8'h71;
  localparam logic [7:0] OFS_IDX1 = 8'h72;
  localparam logic [7:0] OFS_DAT1 = 8'h73;
  // bank 0 indexes
  localparam logic [7:0] IDX_CTL_B = 8'h0b;
  localparam logic [7:0] IDX_FLAGS = 8'h0c;
  localparam logic [7:0] IDX_VALID = 8'h0d;
  // bank 1 indexes
  localparam logic [7:0] IDX_SEC2  = 8'h00;
  localparam logic [7:0] IDX_MIN2  = 8'h01;
  localparam logic [7:0] IDX_HOUR2 = 8'h02;
  localparam logic [7:0] IDX_DAY2  = 8'h03;
  localparam logic [7:0] IDX_MON2  = 8'h04;
  // control b bit positions
  localparam int unsigned BIT_A1IE = 5;
  localparam int unsigned BIT_SECOND_ALARM_IRQ_ENABLE = 3;
  localparam int unsigned BIT_NFMT = 2;
  localparam int unsigned BIT_HFMT = 1;
  // flags register and validity register bit positions
  localparam int unsigned BIT_FIRST_ALARM_FLAG = 5;
  localparam int unsigned BIT_SECOND_ALARM_FLAG = 3;
  localparam int unsigned BIT_VAL  = 7;
  // reset values, don't-care code and field count
  localparam logic [7:0] RST_MON   = 8'hc0;
  localparam logic [7:0] RST_DAY   = 8'hc0;
  localparam logic [7:0] RST_TIME  = 8'h00;
  localparam logic [7:0] RST_IDX   = 8'h00;
  localparam logic [7:0] RST_CTL   = 8'h00;
  localparam logic [1:0] DONT_CARE = 2'b11;
  localparam int unsigned NFIELDS  = 5;

  typedef struct packed {
    logic [7:0] addr;
    logic       wr;
    logic       rd;
    logic [7:0] wdata;
  } rta_bus_t;

  typedef struct packed {
    logic [7:0] sec;
    logic [7:0] min;
    logic [7:0] hour;
    logic [7:0] day;
    logic [7:0] month;
  } rta_time_t;
endpackage : rta_pkg

// [rtl/rta_sticky_flag.sv]
// sticky event flag; a set in the clear cycle wins
`timescale 1ns/10ps
module rta_sticky_flag (
  input  wire logic clk,
  input  wire logic reset,
  input  wire logic set,
  input  wire logic clr,
  output logic      q_r
);
  import rta_pkg::*;

  always_ff @(posedge clk) begin
    if (reset) begin
      q_r <= 1'b0;
    end else begin
      q_r <= set | (q_r & ~clr);
    end
  end

  a_set_wins: assert property (@(posedge clk) disable iff (reset)
    set |=> q_r)
    else $error("flag event lost");
endmodule : rta_sticky_flag

// [test/rta_host_model.sv]
// host software model driving the paired index/data ports
`timescale 1ns/10ps
module rta_host_model (
  input  wire logic         clk,
  input  wire logic [7:0]   host_rdata,
  output rta_pkg::rta_bus_t host
);
  import rta_pkg::*;
  initial host = '0;
  // -------------------------------------------------------
  // single accesses
  // -------------------------------------------------------
  // released address and data lines carry inverted values, strobes go low, so stale data never looks valid
  task automatic put(input logic [7:0] a, input logic [7:0] d, input logic r);
    @(posedge clk);
    #1 host = '{a, ~r, r, d};
    @(posedge clk);
    #1 host = '{~a, 1'b0, 1'b0, ~d};
  endtask : put
  task automatic get(input logic [7:0] a, output logic [7:0] q);
    put(a, 8'h00, 1'b1);
    @(posedge clk);
    #1 q = host_rdata;
  endtask : get
  // -------------------------------------------------------
  // indexed accesses: index first, then data port
  // -------------------------------------------------------
  task automatic bwr(input logic b, input logic [7:0] i, input logic [7:0] d);
    put(b ? OFS_IDX1 : OFS_IDX0, i, 1'b0);
    put(b ? OFS_DAT1 : OFS_DAT0, d, 1'b0);
  endtask : bwr
  task automatic brd(input logic b, input logic [7:0] i, output logic [7:0] q);
    put(b ? OFS_IDX1 : OFS_IDX0, i, 1'b0);
    get(b ? OFS_DAT1 : OFS_DAT0, q);
  endtask : brd
endmodule : rta_host_model

// [test/test_rta_alarm_bank.sv]
// self-checking bench for the alarm bank
`timescale 1ns/10ps
module test_rta_alarm_bank;
  import rta_pkg::*;
  logic       clk, reset, rest_match, valid;
  logic [7:0] rdata, fa_idx, q, d;
  logic       irq, nfmt, hfmt, a1f, a2f;
  rta_bus_t   host;
  rta_time_t  cur_time;
  int         failures, checks_done, seed, k;
  logic [7:0] al [5];
  logic [7:0] tm [5];
  logic [7:0] hr_tab [4] = '{8'h92, 8'h8c, 8'hc5, 8'h17};

  rta_alarm_bank dut_u (.clk(clk), .reset(reset), .host(host), .host_rdata(rdata),
    .first_alarm_month_index(fa_idx), .cur_time(cur_time), .first_alarm_rest_match(rest_match),
    .contents_valid_status(valid), .irq(irq), .number_format_select(nfmt),
    .hour_format_select(hfmt), .first_alarm_flag(a1f), .second_alarm_flag(a2f));
  rta_host_model host_u (.clk(clk), .host_rdata(rdata), .host(host));

  // -------------------------------------------------------
  // expectations, checks and closing
  // -------------------------------------------------------
  function automatic logic [7:0] rst_val(input int f);
    return (f >= 3) ? RST_DAY : RST_TIME;
  endfunction : rst_val
  function automatic logic [7:0] flags_val(input logic a1, input logic a2);
    return (8'(a1) << BIT_FIRST_ALARM_FLAG) | (8'(a2) << BIT_SECOND_ALARM_FLAG);
  endfunction : flags_val
  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp) begin
      failures++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk8
  task automatic chk1(input logic got, input logic exp);
    checks_done++;
    if (got !== exp) begin
      failures++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk1
  task automatic conclude;
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : conclude
  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : step

  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  // run needs well under 2000 cycles
  initial begin
    #200000;
    failures++;
    conclude();
  end

  // -------------------------------------------------------
  // main sequence
  // -------------------------------------------------------
  initial begin
    seed = 32'h876a;
    reset = 1'b1;
    rest_match = 1'b0;
    valid = 1'b1;
    cur_time = '1;
    fa_idx = 8'h20 | (8'($random(seed)) & 8'h0f);
    step(2);
    reset = 1'b0;
    for (int f = 0; f < 5; f++) begin
      host_u.brd(1'b1, 8'(f), q);
      chk8(q, rst_val(f));
    end
    host_u.brd(1'b0, fa_idx, q);
    chk8(q, RST_MON);
    host_u.bwr(1'b0, IDX_FLAGS, 8'hff);
    host_u.brd(1'b0, IDX_FLAGS, q);
    chk8(q, 8'h00);
    host_u.get(8'h74, q);
    chk8(q, 8'h00);
    host_u.get(OFS_IDX0, q);
    chk8(q, IDX_FLAGS);
    host_u.get(OFS_IDX1, q);
    chk8(q, IDX_MON2);
    // random write and read-back over both banks
    repeat (10) begin
      k = int'(8'($random(seed)) % 8'd6);
      d = 8'($random(seed)) & 8'h7f;
      host_u.bwr(k != 5, (k == 5) ? fa_idx : 8'(k), d);
      host_u.brd(k != 5, (k == 5) ? fa_idx : 8'(k), q);
      chk8(q, d);
    end
    host_u.bwr(1'b0, IDX_CTL_B, 8'h08);
    chk1(nfmt, 1'b0);
    chk1(hfmt, 1'b0);
    // second alarm: match, mismatch, don't-care, 24-hour
    for (int p = 0; p < 4; p++) begin
      cur_time = '1;
      if (p == 3) host_u.bwr(1'b0, IDX_CTL_B, 8'h0e);
      for (int f = 0; f < 5; f++) begin
        al[f] = 8'($random(seed)) & 8'h3f;
        tm[f] = al[f];
        if (p == 2 && f > 0) begin
          al[f] = al[f] | 8'hc0;
          tm[f] = 8'($random(seed));
        end
      end
      al[2] = hr_tab[p];
      if (p != 2) tm[2] = hr_tab[p];
      if (p == 1) tm[4] = tm[4] ^ 8'h01;
      for (int f = 0; f < 5; f++) host_u.bwr(1'b1, 8'(f), al[f]);
      cur_time = '{tm[0], tm[1], tm[2], tm[3], tm[4]};
      for (int n = 0; n < 8 && a2f !== 1'b1; n++) step(1);
      chk1(a2f, p != 1);
      step(1);
      chk1(irq, p != 1);
      host_u.brd(1'b0, IDX_FLAGS, q);
      chk8(q, flags_val(1'b0, p != 1));
      step(3);
      chk1(a2f, 1'b0);
    end
    chk1(nfmt, 1'b1);
    chk1(hfmt, 1'b1);
    // first alarm month at its programmed index, then invalid contents
    cur_time = '1;
    host_u.bwr(1'b0, fa_idx, 8'h0c);
    host_u.bwr(1'b0, IDX_CTL_B, 8'h2e);
    cur_time.month = 8'h0c;
    rest_match = 1'b1;
    step(4);
    chk1(a1f, 1'b1);
    chk1(irq, 1'b1);
    host_u.brd(1'b0, IDX_FLAGS, q);
    chk8(q, flags_val(1'b1, 1'b0));
    rest_match = 1'b0;
    step(2);
    rest_match = 1'b1;
    step(4);
    chk1(a1f, 1'b1);
    valid = 1'b0;
    step(2);
    chk1(a1f, 1'b0);
    host_u.brd(1'b0, IDX_CTL_B, q);
    chk8(q, 8'h06);
    host_u.brd(1'b0, IDX_VALID, q);
    chk8(q, 8'h00);
    rest_match = 1'b0;
    step(2);
    rest_match = 1'b1;
    step(4);
    chk1(a1f, 1'b0);
    conclude();
  end
endmodule : test_rta_alarm_bank
